// ==== verilog/ce_guard_regs.vh ====
`ifndef CE_GUARD_REGS_VH
`define CE_GUARD_REGS_VH
`define CLK_FREQ_HZ 125000000
`define COMPLETE_WINDOW_US 18
`define RESET_TIMEOUT_MS 200
`define COMPLETE_WINDOW_CYC ((`CLK_FREQ_HZ / 1000000) * `COMPLETE_WINDOW_US)
`define RESET_TIMEOUT_CYC ((`CLK_FREQ_HZ / 1000) * `RESET_TIMEOUT_MS)
`define CS_OUT_IDLE 1'b1
`define OE_INIT 1'b1
`define PULLUP_INIT 1'b1
`define SUP_RESET_INIT 1'b1
`define BACKUP_INIT 1'b0
`define SYNC_SUPPLY_INIT 1'b1
`define SYNC_SELECT_INIT 1'b1
`define SYNC_LEVEL_INIT 1'b0
`endif

// ==== verilog/level_sync.v ====
`timescale 1ns/1ps
module level_sync #(
   parameter RESET_VALUE = 1'b0
) (
   input wire mclk,
   input wire resetn,
   input wire din,
   output reg dout
);
   reg stage1;

   // stage1 feeds only dout, keeping metastability contained
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stage1 <= RESET_VALUE;
         dout <= RESET_VALUE;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule

// ==== verilog/ram_chip_enable_write_guard.v ====
// Contract
// - reset mid-write keeps path open 18us
// - window expiry with select low blocks path
// - select released in window blocks immediately
// - once blocked, output stays high until reset clears
// - reset with window over ignores select
// - power-up keeps path blocked until timeout
// - pull-up active only while path disabled
// - backup only below threshold, entered below backup level
// - switchover uses hysteresis
// - normal mode passes select straight through
// - reset held 200ms, restarts on dips
`timescale 1ns/1ps
`include "ce_guard_regs.vh"
module ram_chip_enable_write_guard #(
   parameter WINDOW_CYC = `COMPLETE_WINDOW_CYC,
   parameter TIMEOUT_CYC = `RESET_TIMEOUT_CYC
) (
   input wire mclk,
   input wire resetn,
   input wire chip_select_in_n,
   input wire supply_below_threshold,
   input wire supply_below_backup,
   input wire supply_above_backup_hyst,
   output reg chip_select_out_n,
   output reg chip_select_out_oe,
   output reg pullup_enable,
   output reg supervisor_reset,
   output reg backup_mode
);
   // 32-bit counters cover the 200ms count at any sane clock
   localparam CW = 32;
   // binary state codes
   localparam [1:0] ST_RESET = 2'h0;
   localparam [1:0] ST_PASS = 2'h1;
   localparam [1:0] ST_WINDOW = 2'h2;
   localparam [1:0] ST_BLOCK = 2'h3;
   wire below_thr;
   wire below_bak;
   wire above_hyst;
   wire cs_sync;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [CW-1:0] win_cnt;
   reg [CW-1:0] tmo_cnt;
   reg on_backup;
   reg next_pass;
   reg next_on_backup;
   reg next_supervisor_reset;
   reg [CW-1:0] next_tmo_cnt;
   reg [CW-1:0] next_win_cnt;

   // select reaches the ram only in pass and write-completion states
   function path_open;
      input [1:0] st;
      begin
         path_open = (st == ST_PASS) || (st == ST_WINDOW);
      end
   endfunction

   level_sync #(.RESET_VALUE(`SYNC_SUPPLY_INIT)) sync_thr (
      .mclk(mclk),
      .resetn(resetn),
      .din(supply_below_threshold),
      .dout(below_thr)
   );
   level_sync #(.RESET_VALUE(`SYNC_LEVEL_INIT)) sync_bak (
      .mclk(mclk),
      .resetn(resetn),
      .din(supply_below_backup),
      .dout(below_bak)
   );
   level_sync #(.RESET_VALUE(`SYNC_LEVEL_INIT)) sync_hys (
      .mclk(mclk),
      .resetn(resetn),
      .din(supply_above_backup_hyst),
      .dout(above_hyst)
   );
   // idle select is high: a low reset value would fake a write
   level_sync #(.RESET_VALUE(`SYNC_SELECT_INIT)) sync_cs (
      .mclk(mclk),
      .resetn(resetn),
      .din(chip_select_in_n),
      .dout(cs_sync)
   );

   // reset timeout: restarts whenever supply dips again
   always @* begin
      next_tmo_cnt = tmo_cnt;
      next_supervisor_reset = supervisor_reset;
      if (below_thr) begin
         next_tmo_cnt = {CW{1'b0}};
         next_supervisor_reset = 1'b1;
      end else if (supervisor_reset) begin
         if (tmo_cnt >= TIMEOUT_CYC - 1) begin
            next_supervisor_reset = 1'b0;
         end else begin
            next_tmo_cnt = tmo_cnt + 1'b1;
         end
      end
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tmo_cnt <= {CW{1'b0}};
         supervisor_reset <= `SUP_RESET_INIT;
      end else begin
         tmo_cnt <= next_tmo_cnt;
         supervisor_reset <= next_supervisor_reset;
      end
   end

   // hysteresis: leave backup only above level plus margin
   always @* begin
      next_on_backup = on_backup;
      if (below_bak) begin
         next_on_backup = 1'b1;
      end else if (above_hyst) begin
         next_on_backup = 1'b0;
      end
   end

   // backup needs both: a sagging supply above battery stays on main
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         on_backup <= `BACKUP_INIT;
         backup_mode <= `BACKUP_INIT;
      end else begin
         on_backup <= next_on_backup;
         backup_mode <= on_backup & below_thr;
      end
   end

   // path state machine
   always @* begin
      next_state = state;
      case (state)
         ST_RESET: begin
            if (!supervisor_reset) begin
               next_state = ST_PASS;
            end
         end
         ST_PASS: begin
            // a write already in flight gets the completion window
            if (supervisor_reset) begin
               if (!cs_sync) begin
                  next_state = ST_WINDOW;
               end else begin
                  next_state = ST_BLOCK;
               end
            end
         end
         ST_WINDOW: begin
            // release during the window closes the gate at once
            if (cs_sync) begin
               next_state = ST_BLOCK;
            end else if (win_cnt >= WINDOW_CYC - 1) begin
               next_state = ST_BLOCK;
            end
         end
         default: begin
            // blocked until reset clears; select ignored
            if (!supervisor_reset) begin
               next_state = ST_PASS;
            end
         end
      endcase
   end

   // count on the next state so the path closes exactly
   // WINDOW_CYC cycles after reset asserts
   always @* begin
      if (next_state == ST_WINDOW) begin
         next_win_cnt = win_cnt + 1'b1;
      end else begin
         next_win_cnt = {CW{1'b0}};
      end
   end

   // a cut write never resumes: only a cleared reset reopens
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_RESET;
         win_cnt <= {CW{1'b0}};
      end else begin
         state <= next_state;
         win_cnt <= next_win_cnt;
      end
   end

   always @* begin
      next_pass = path_open(next_state);
   end

   // pass path registered; adds synchroniser latency, no glitch passing
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         chip_select_out_n <= `CS_OUT_IDLE;
      end else begin
         chip_select_out_n <= next_pass ? cs_sync : `CS_OUT_IDLE;
      end
   end

   // pin always driven: passed select or the pull-up level
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         chip_select_out_oe <= `OE_INIT;
      end else begin
         chip_select_out_oe <= 1'b1;
      end
   end

   // pull-up drops in the same edge the gate opens, never before
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pullup_enable <= `PULLUP_INIT;
      end else begin
         pullup_enable <= ~next_pass;
      end
   end
endmodule

// ==== dv/ceg_checker.sv ====
`timescale 1ns/1ps
module ceg_checker #(parameter WINDOW_CYC = 20) (
   input wire mclk,
   input wire resetn,
   input wire chip_select_in_n,
   input wire supply_below_threshold,
   input wire chip_select_out_n,
   input wire pullup_enable,
   input wire supervisor_reset,
   input wire backup_mode
);
   localparam int WMAX = WINDOW_CYC + 4;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_pass_follows: assert property ((!supervisor_reset)[*5] |->
      chip_select_out_n == $past(chip_select_in_n, 3)) else $error("pass");
   a_low_path_only: assert property (!chip_select_out_n |->
      !pullup_enable) else $error("pullup");
   a_blocked_high: assert property (supervisor_reset && pullup_enable |->
      chip_select_out_n) else $error("blocked");
   a_block_sticky: assert property (supervisor_reset && pullup_enable |=>
      pullup_enable || !supervisor_reset) else $error("sticky");
   a_window_end: assert property ($rose(supervisor_reset) &&
      !chip_select_out_n |-> ##[1:WMAX] pullup_enable) else $error("window");
   a_early_close: assert property (supervisor_reset && !pullup_enable &&
      $rose(chip_select_in_n) |-> ##[1:5] pullup_enable) else $error("early");
   a_backup_low: assert property (backup_mode |->
      $past(supply_below_threshold, 3) || $past(supply_below_threshold, 4))
      else $error("backup");
   a_low_resets: assert property ($past(supply_below_threshold, 3) |->
      supervisor_reset) else $error("reset");
endmodule
bind ram_chip_enable_write_guard ceg_checker #(.WINDOW_CYC(WINDOW_CYC))
   chk (
      .mclk(mclk),
      .resetn(resetn),
      .chip_select_in_n(chip_select_in_n),
      .supply_below_threshold(supply_below_threshold),
      .chip_select_out_n(chip_select_out_n),
      .pullup_enable(pullup_enable),
      .supervisor_reset(supervisor_reset),
      .backup_mode(backup_mode)
   );

// ==== dv/host_model.sv ====
`timescale 1ns/1ps
module host_model (
   input wire mclk,
   input wire start,
   input wire [7:0] write_len,
   output reg chip_select_in_n = 1'b1
);
   reg [7:0] left = 8'h00;
   // select held through the whole write, never cut short
   always @(posedge mclk) begin
      if (start) begin
         chip_select_in_n <= 1'b0;
         left <= write_len;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
         chip_select_in_n <= left == 8'h01;
      end
   end
endmodule

// ==== dv/ram_chip_enable_write_guard_tb_top.sv ====
`timescale 1ns/1ps
module ram_chip_enable_write_guard_tb_top;
   reg mclk = 0, resetn = 0, start = 0, supply_below_threshold = 0;
   reg supply_below_backup = 0, supply_above_backup_hyst = 1;
   reg [7:0] write_len = 8'h01;
   wire chip_select_in_n, chip_select_out_n, chip_select_out_oe;
   wire pullup_enable, supervisor_reset, backup_mode;
   logic exp_q[$];
   logic e;
   int bad_count = 0, checks_done = 0, t;
   ram_chip_enable_write_guard #(.WINDOW_CYC(20), .TIMEOUT_CYC(100)) uut (
      .mclk(mclk),
      .resetn(resetn),
      .chip_select_in_n(chip_select_in_n),
      .supply_below_threshold(supply_below_threshold),
      .supply_below_backup(supply_below_backup),
      .supply_above_backup_hyst(supply_above_backup_hyst),
      .chip_select_out_n(chip_select_out_n),
      .chip_select_out_oe(chip_select_out_oe),
      .pullup_enable(pullup_enable),
      .supervisor_reset(supervisor_reset),
      .backup_mode(backup_mode)
   );
   host_model host (
      .mclk(mclk),
      .start(start),
      .write_len(write_len),
      .chip_select_in_n(chip_select_in_n)
   );
   initial forever #4 mclk = ~mclk;
   task results;
      $display("bad_count %0d checks_done %0d", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string n, input logic s, input logic x);
      checks_done++;
      if (s !== x) begin
         bad_count++;
         $display("Error %s expected %b seen %b", n, x, s);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // edges expected on the output are queued before the write starts
   task wr(input int n, input bit x);
      if (x) exp_q = {exp_q, 1'b0, 1'b1};
      @(negedge mclk) write_len = 8'(n);
      start = 1;
      cyc(1);
      start = 0;
   endtask
   always @(chip_select_out_n) if (resetn) begin
      e = exp_q.size() ? exp_q.pop_front() : 1'bx;
      chk("out_n", chip_select_out_n, e);
   end
   initial begin
      #40000;
      bad_count++;
      results;
   end
   initial begin
      void'($urandom(32'h6df7));
      cyc(10);
      resetn = 1;
      wr(8, 0);
      cyc(90);
      chk("sup", supervisor_reset, 1);
      chk("pullup", pullup_enable, 1);
      cyc(20);
      chk("sup", supervisor_reset, 0);
      chk("pullup", pullup_enable, 0);
      chk("oe", chip_select_out_oe, 1);
      repeat (4) begin
         wr($urandom_range(12, 1), 1);
         cyc(20);
      end
      for (int k = 0; k < 2; k++) begin
         wr(k ? 14 : 60, 1);
         cyc(4);
         supply_below_threshold = 1;
         @(posedge supervisor_reset);
         t = 0;
         while (chip_select_out_n !== 1'b1 && t < 40) begin
            @(negedge mclk);
            t++;
         end
         // 20-cycle window, seen at the falling edge after it closes
         chk("window", k ? t < 21 : t == 21, 1);
         chk("pullup", pullup_enable, 1);
         cyc(40);
         wr(5, 0);
         cyc(10);
         supply_below_backup = 1;
         supply_above_backup_hyst = 0;
         cyc(6);
         chk("backup", backup_mode, 1);
         supply_below_backup = 0;
         cyc(6);
         chk("backup", backup_mode, 1);
         supply_above_backup_hyst = 1;
         cyc(6);
         chk("backup", backup_mode, 0);
         supply_below_threshold = 0;
         cyc(110);
         chk("sup", supervisor_reset, 0);
      end
      chk("queue", exp_q.size() == 0, 1);
      results;
   end
endmodule
